// [dv/tb.sv]
`timescale 1ns/1ns
module tb;
    import tors_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [9:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic        pready, pslverr, e;
    logic [15:0] timing_sources;
    logic [2:0]  audio_clock_out_two_rate, audio_clock_out_three_rate;
    logic [3:0]  timing_pin, timing_pin_strong;
    int miscompares = 0, comparisons = 0, cyc = 0;
    localparam logic [9:0] AD [6] = '{10'h100, 10'h104, 10'h10C, 10'h110,
        10'h114, 10'h118};
    initial forever #50 pclk = ~pclk;
    tors_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .timing_sources,
        .audio_clock_out_two_rate, .audio_clock_out_three_rate,
        .timing_pin, .timing_pin_strong);
    tors_far far_u (.pclk, .presetn, .timing_sources);
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", n, x, g);
        end
    endtask : chk
    // one apb transfer; waits on pready, the hang guard ends a stuck wait
    task automatic xfer(logic w, logic [9:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : xfer
    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            wrap_up;
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 6; i++) begin
            xfer(0, AD[i], 0);
            chk("reset value", i < 2 ? 0 : i - 1, q);
        end
        chk("default pin", timing_sources[1], timing_pin[0]);
        // every rate code on both clocks, opposite codes to catch cross-talk
        for (int v = 0; v < 8; v++) begin
            xfer(1, 10'h100, v);
            xfer(1, 10'h104, 7 - v);
            xfer(0, 10'h104, 0);
            chk("rate three", 7 - v, q);
            chk("rate two out", v, audio_clock_out_two_rate);
        end
        // every source code on every pin, drive bit from c[3], which on pin one equals code bit 3
        for (int c = 0; c < 16; c++)
            for (int p = 0; p < 4; p++) begin
                int k;
                k = (c + p) % 16;
                xfer(1, AD[p + 2], 32'({c[3], k[3:0]}));
                xfer(0, AD[p + 2], 0);
                chk("selector", 32'({c[3], k[3:0]}), q);
                chk("pin", timing_sources[k], timing_pin[p]);
                chk("drive", c[3], timing_pin_strong[p]);
            end
        xfer(1, 10'h108, 32'h7);
        chk("reserved error", 1, e);
        wrap_up;
    end
endmodule : tb
bind tors_regs tors_sva sva_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .timing_sources,
    .audio_clock_out_two_rate, .audio_clock_out_three_rate, .timing_pin,
    .timing_pin_strong);

// [dv/tors_far.sv]
`timescale 1ns/1ns
// far-side timing generators; a twisted ring so every source toggles
module tors_far (
    input wire logic    pclk,
    input wire logic    presetn,
    output logic [15:0] timing_sources
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) timing_sources <= 16'h00FF;
        else timing_sources <= {timing_sources[14:0], ~timing_sources[15]};
    end
endmodule : tors_far

// [dv/tors_sva.sv]
`timescale 1ns/1ns
// port checks of the rate and pin select registers
module tors_sva
    import tors_pkg::*;
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [tors_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [15:0]           timing_sources,
    input wire logic [2:0]            audio_clock_out_two_rate,
    input wire logic [2:0]            audio_clock_out_three_rate,
    input wire logic [3:0]            timing_pin,
    input wire logic [3:0]            timing_pin_strong
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a write lands at the edge that ends its access phase
    wire logic wr = psel && penable && pwrite;
    a_rate_two_wr: assert property (wr && paddr == 10'h100 |=>
        audio_clock_out_two_rate == $past(pwdata[2:0]))
        else $error("rate two");
    a_rate_three_wr: assert property (wr && paddr == 10'h104 |=>
        audio_clock_out_three_rate == $past(pwdata[2:0]))
        else $error("rate 3");
    a_pin_four_src: assert property (wr && paddr == 10'h118 |=>
        timing_pin[3] == timing_sources[$past(pwdata[3:0])])
        else $error("pin");
    a_drive_one_wr: assert property (wr && paddr == 10'h10C |=>
        timing_pin_strong[0] == $past(pwdata[4])) else $error("drive");
    a_reset_vals: assert property ($rose(presetn) |->
        {audio_clock_out_two_rate, timing_pin_strong} == 7'h00)
        else $error("rst");
    a_rate_hold: assert property (!wr |=>
        $stable(audio_clock_out_three_rate)) else $error("rate moved");
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("wait state");
    a_reserved_err: assert property (psel && penable && paddr == 10'h108
        |-> pslverr) else $error("no error on reserved word");
endmodule : tors_sva

// [shared/tors_pkg.sv]
package tors_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_CLK2_RATE  = 8'h40;
    localparam logic [7:0] IDX_CLK3_RATE  = 8'h41;
    localparam logic [7:0] IDX_PIN1_SEL   = 8'h43;
    localparam logic [7:0] IDX_PIN2_SEL   = 8'h44;
    localparam logic [7:0] IDX_PIN3_SEL   = 8'h45;
    localparam logic [7:0] IDX_PIN4_SEL   = 8'h46;
    localparam int         ADDR_W         = 10;
    localparam int         NUM_PINS       = 4;
    localparam int         NUM_SOURCES    = 16;
    // field layout
    localparam int         RATE_LSB       = 0;
    localparam int         RATE_W         = 3;
    localparam int         SRC_LSB        = 0;
    localparam int         SRC_W          = 4;
    localparam int         DRIVE_BIT      = 4;
    // reset values
    localparam logic [2:0] RATE_RST       = 3'h0;
    localparam logic [3:0] PIN1_SRC_RST   = 4'h1;
    localparam logic [3:0] PIN2_SRC_RST   = 4'h2;
    localparam logic [3:0] PIN3_SRC_RST   = 4'h3;
    localparam logic [3:0] PIN4_SRC_RST   = 4'h4;
    localparam logic       DRIVE_RST      = 1'b0;
endpackage : tors_pkg

// [verilog/tors_pin_mux.sv]
`timescale 1ns/1ns
// routes one of the selectable timing sources onto a timing pin
module tors_pin_mux #(
    parameter int SRC_N = 16,
    parameter int SEL_W = 4
) (
    input  wire logic [SRC_N-1:0] sources,
    input  wire logic [SEL_W-1:0] sel,
    output logic                  pin_out
);
    // pure mux: selector changes act with no extra step
    always_comb begin
        pin_out = sources[sel];
    end
endmodule : tors_pin_mux

// [verilog/tors_regs.sv]
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
// Functional notes
// - bits 2-0 at 40h pick audio clock two rate multiple; reset 0
// - bits 2-0 at 41h pick audio clock three rate multiple; reset 0
// - bits 3-0 of 43h-46h choose timing source for pins one to four
// - bit 4 sets pin drive strength, high strong; reset 0
// - pin one selector resets to 0001b, horizontal sync
// - pin two selector resets to 0010b, horizontal blanking
// - pin three selector resets to 0011b, vertical sync
// - pin four selector resets to 0100b, vertical blanking
module tors_regs
    import tors_pkg::*;
#(
    parameter int SRC_N = tors_pkg::NUM_SOURCES
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [tors_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [SRC_N-1:0]           timing_sources,
    output logic      [2:0]                 audio_clock_out_two_rate,
    output logic      [2:0]                 audio_clock_out_three_rate,
    output logic      [tors_pkg::NUM_PINS-1:0] timing_pin,
    output logic      [tors_pkg::NUM_PINS-1:0] timing_pin_strong
);
    import tors_pkg::*;

    logic [RATE_W-1:0] rate2;
    logic [RATE_W-1:0] rate3;
    logic [SRC_W-1:0]  src_sel [NUM_PINS];
    logic [NUM_PINS-1:0] drive;
    logic              wr_en;
    logic              rd_en;
    logic              hit;
    logic [7:0]        idx;
    logic [31:0]       next_prdata;

    // word index from byte address; low two bits must be zero
    function automatic logic [7:0] word_index(
        input logic [ADDR_W-1:0] a);
        word_index = a[9:2];
    endfunction : word_index

    // selector register index for pin n
    function automatic logic [7:0] pin_index(input int n);
        pin_index = 8'(IDX_PIN1_SEL + 8'(n));
    endfunction : pin_index

    assign idx   = word_index(paddr);
    assign wr_en = psel && penable && pwrite && hit;
    assign rd_en = psel && penable && !pwrite;

    // zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;

    // decode of mapped words; misaligned or unmapped gives an error
    always_comb begin
        hit = 1'b0;
        if (paddr[1:0] == 2'h0) begin
            hit = (idx == IDX_CLK2_RATE) || (idx == IDX_CLK3_RATE);
            for (int i = 0; i < NUM_PINS; i++) begin
                if (idx == pin_index(i)) begin
                    hit = 1'b1;
                end
            end
        end
    end

    assign pslverr = psel && penable && !hit;

    // audio clock two rate field; upper bits not stored (host writes 0)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate2 <= RATE_RST;
        end else if (wr_en && idx == IDX_CLK2_RATE) begin
            rate2 <= pwdata[RATE_LSB +: RATE_W];
        end
    end

    // audio clock three rate field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate3 <= RATE_RST;
        end else if (wr_en && idx == IDX_CLK3_RATE) begin
            rate3 <= pwdata[RATE_LSB +: RATE_W];
        end
    end

    // the 384/192 multiples also need an enable held elsewhere; not here
    assign audio_clock_out_two_rate   = rate2;
    assign audio_clock_out_three_rate = rate3;

    // timing pin source selectors with their documented defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_sel[0] <= PIN1_SRC_RST;
            src_sel[1] <= PIN2_SRC_RST;
            src_sel[2] <= PIN3_SRC_RST;
            src_sel[3] <= PIN4_SRC_RST;
        end else if (wr_en) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                if (idx == pin_index(i)) begin
                    src_sel[i] <= pwdata[SRC_LSB +: SRC_W];
                end
            end
        end
    end

    // drive strength bits, one per pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive <= '0;
        end else if (wr_en) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                if (idx == pin_index(i)) begin
                    drive[i] <= pwdata[DRIVE_BIT];
                end
            end
        end
    end

    assign timing_pin_strong = drive;

    // read mux; unused upper bits read as zero
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (idx == IDX_CLK2_RATE) begin
            next_prdata[RATE_LSB +: RATE_W] = rate2;
        end else if (idx == IDX_CLK3_RATE) begin
            next_prdata[RATE_LSB +: RATE_W] = rate3;
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                if (idx == pin_index(i)) begin
                    next_prdata[SRC_LSB +: SRC_W] = src_sel[i];
                    next_prdata[DRIVE_BIT]        = drive[i];
                end
            end
        end
        if (paddr[1:0] != 2'h0) begin
            next_prdata = 32'h0000_0000;
        end
    end

    // read data registered in setup phase so it is valid in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end else if (rd_en) begin
            prdata <= next_prdata;
        end
    end

    // one mux per timing pin, follows its selector at once
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
        tors_pin_mux #(
            .SRC_N (SRC_N),
            .SEL_W (SRC_W)
        ) u_mux (
            .sources (timing_sources),
            .sel     (src_sel[g]),
            .pin_out (timing_pin[g])
        );
    end
endmodule : tors_regs
